//--- hw/pmr_mgmt_top.sv
// Management register block with its serial management frame engine.
`timescale 1ns/1ns
`include "pmr_params.svh"
module pmr_mgmt_top (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        ten_bit_interface_mode_in,
    input  wire logic        mgmt_clock_bit_in,
    input  wire logic        mgmt_data_bit_in,
    output logic             mgmt_data_bit_out,
    output logic             mgmt_data_oe_n_out,
    input  wire logic [15:0] page_word_in,
    input  wire logic        page_rx_in,
    output logic             loopback_wrap_output_out,
    output logic             pcs_reset_out,
    output logic             an_enable_out,
    output logic             an_restart_out,
    output logic             full_duplex_out,
    output logic             col_test_out
);
    pmr_regbus_if bus ();

    logic [1:0]                pin_lvl;
    logic                      mdc_prev_r;
    logic                      rise;
    logic                      din;
    pmr_pkg::pmr_frame_state_t state_r;
    logic [5:0]                cnt_r;
    logic [11:0]               hdr_r;
    logic [12:0]               hdr_full;
    logic                      is_rd_r;
    logic [15:0]               tx_r;
    logic [15:0]               wdata_r;
    logic [4:0]                addr_r;
    logic                      rd_stb_r;
    logic                      wr_stb_r;
    logic                      hdr_ok;

    pmr_sync3 #(.W(2)) u_sync (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .async_in  ({mgmt_clock_bit_in, mgmt_data_bit_in}),
        .level_out (pin_lvl)
    );

    assign din      = pin_lvl[0];
    assign rise     = pin_lvl[1] && !mdc_prev_r;
    assign hdr_full = {hdr_r, din};
    // Start bit one, our address, a known opcode, and only in ten-bit interface mode.
    assign hdr_ok   = hdr_full[12] && (hdr_full[9:5] == `PMR_PHY_ADDR) &&
                      ten_bit_interface_mode_in &&
                      (hdr_full[11:10] == `PMR_OP_READ || hdr_full[11:10] == `PMR_OP_WRITE);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mdc_prev_r <= 1'b0;
        end else begin
            mdc_prev_r <= pin_lvl[1];
        end
    end

    // Frame sequencing; every field is sampled on a rising management clock edge.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r <= pmr_pkg::PMR_ST_PRE;
            cnt_r   <= 6'h00;
            hdr_r   <= 12'h000;
            is_rd_r <= 1'b0;
            addr_r  <= 5'h00;
        end else if (rise) begin
            unique case (state_r)
                pmr_pkg::PMR_ST_PRE: begin
                    if (din) begin
                        if (cnt_r != `PMR_PREAMBLE_LEN) begin
                            cnt_r <= cnt_r + 6'h01;
                        end
                    end else if (cnt_r == `PMR_PREAMBLE_LEN) begin
                        state_r <= pmr_pkg::PMR_ST_HDR;
                        cnt_r   <= 6'h00;
                    end else begin
                        cnt_r <= 6'h00;
                    end
                end
                pmr_pkg::PMR_ST_HDR: begin
                    hdr_r <= hdr_full[11:0];
                    if (cnt_r == `PMR_HDR_LAST) begin
                        cnt_r   <= 6'h00;
                        is_rd_r <= (hdr_full[11:10] == `PMR_OP_READ);
                        addr_r  <= hdr_full[4:0];
                        state_r <= hdr_ok ? pmr_pkg::PMR_ST_TA : pmr_pkg::PMR_ST_PRE;
                    end else begin
                        cnt_r <= cnt_r + 6'h01;
                    end
                end
                pmr_pkg::PMR_ST_TA: begin
                    if (cnt_r == 6'h01) begin
                        state_r <= pmr_pkg::PMR_ST_DATA;
                        cnt_r   <= 6'h00;
                    end else begin
                        cnt_r <= cnt_r + 6'h01;
                    end
                end
                pmr_pkg::PMR_ST_DATA: begin
                    // A fresh preamble is required for each frame: no suppression.
                    if (cnt_r == `PMR_DATA_LAST) begin
                        state_r <= pmr_pkg::PMR_ST_PRE;
                        cnt_r   <= 6'h00;
                    end else begin
                        cnt_r <= cnt_r + 6'h01;
                    end
                end
            endcase
        end
    end

    // Strobes toward the bank last one clock cycle each.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_stb_r <= 1'b0;
            wr_stb_r <= 1'b0;
        end else begin
            rd_stb_r <= rise && state_r == pmr_pkg::PMR_ST_HDR && cnt_r == `PMR_HDR_LAST &&
                        hdr_ok && hdr_full[11:10] == `PMR_OP_READ;
            wr_stb_r <= rise && state_r == pmr_pkg::PMR_ST_DATA &&
                        cnt_r == `PMR_DATA_LAST && !is_rd_r;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wdata_r <= 16'h0000;
        end else if (rise && state_r == pmr_pkg::PMR_ST_DATA && !is_rd_r) begin
            wdata_r <= {wdata_r[14:0], din};
        end
    end

    // Read data is latched in the strobe cycle, before clear-on-read bits drop.
    // The host samples on its rising edge, so the device changes the line just after one.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_r               <= 16'h0000;
            mgmt_data_bit_out  <= 1'b1;
            mgmt_data_oe_n_out <= 1'b1;
        end else if (rd_stb_r) begin
            tx_r <= bus.rdata;
        end else if (rise && is_rd_r) begin
            if (state_r == pmr_pkg::PMR_ST_TA && cnt_r == 6'h00) begin
                mgmt_data_bit_out  <= 1'b0;
                mgmt_data_oe_n_out <= 1'b0;
            end else if (state_r == pmr_pkg::PMR_ST_DATA && cnt_r == `PMR_DATA_LAST) begin
                mgmt_data_bit_out  <= 1'b1;
                mgmt_data_oe_n_out <= 1'b1;
            end else if (state_r == pmr_pkg::PMR_ST_TA || state_r == pmr_pkg::PMR_ST_DATA) begin
                mgmt_data_bit_out <= tx_r[15];
                tx_r              <= {tx_r[14:0], 1'b0};
            end
        end
    end

    assign bus.rd_stb = rd_stb_r;
    assign bus.wr_stb = wr_stb_r;
    assign bus.addr   = addr_r;
    assign bus.wdata  = wdata_r;

    pmr_reg_bank u_bank (
        .clk_in                   (clk_in),
        .rst_n_in                 (rst_n_in),
        .bus                      (bus.bank),
        .page_word_in             (page_word_in),
        .page_rx_in               (page_rx_in),
        .loopback_wrap_output_out (loopback_wrap_output_out),
        .pcs_reset_out            (pcs_reset_out),
        .an_enable_out            (an_enable_out),
        .an_restart_out           (an_restart_out),
        .full_duplex_out          (full_duplex_out),
        .col_test_out             (col_test_out)
    );

    property p_foreign_addr;
        @(posedge clk_in) disable iff (!rst_n_in)
        (rise && state_r == pmr_pkg::PMR_ST_HDR && cnt_r == 6'h0C && hdr_full[9:5] != 5'h01)
            |=> (state_r == pmr_pkg::PMR_ST_PRE) && !rd_stb_r;
    endproperty
    a_foreign_addr: assert property (p_foreign_addr)
        else $error("Frame for another address was taken.");

    property p_mode_gate;
        @(posedge clk_in) disable iff (!rst_n_in)
        (rise && state_r == pmr_pkg::PMR_ST_HDR && cnt_r == 6'h0C && !ten_bit_interface_mode_in)
            |=> (state_r == pmr_pkg::PMR_ST_PRE);
    endproperty
    a_mode_gate: assert property (p_mode_gate)
        else $error("Frame taken outside ten-bit interface mode.");

    property p_turnaround_zero;
        @(posedge clk_in) disable iff (!rst_n_in)
        $fell(mgmt_data_oe_n_out) |-> !mgmt_data_bit_out && state_r == pmr_pkg::PMR_ST_TA;
    endproperty
    a_turnaround_zero: assert property (p_turnaround_zero)
        else $error("Turnaround did not drive zero.");

    property p_no_drive_on_write;
        @(posedge clk_in) disable iff (!rst_n_in)
        !is_rd_r |-> mgmt_data_oe_n_out;
    endproperty
    a_no_drive_on_write: assert property (p_no_drive_on_write)
        else $error("Data line driven during a write frame.");
endmodule : pmr_mgmt_top

//--- hw/pmr_params.svh
// Constants for the coding sublayer management registers and their serial access.
// Notes on behaviour
// - Control register comes out of reset holding 0x1140.
// - Writing one to control bit 15 resets the coding sublayer logic.
// - Control bit 14 drives the loopback wrap output high when set.
// - Speed bits read fixed: bit 13 zero, bit 6 one; writes ignored.
// - Control bit 12 enables auto-negotiation when one.
// - Control bit 11, power-down, is read-only zero.
// - Control bit 10, isolate, is read-only zero.
// - Writing one to control bit 9 restarts auto-negotiation.
// - Bit 8 selects full duplex; bit 7 enables the collision signal test.
// - Expansion register at 0x06 resets to 0x0004; bit 2 reads one.
// - Expansion bit 1 reads one once a new partner page has arrived.
// - Extended status at 0x0F resets to 0xC000; bits 15 and 14 read one.
// - Extended status bits 13 to 0 read zero.
// - Partner base page at 0x05 is read-only, resets to zero, holds received word.
// - Partner page bit 15 is next page, bit 14 is acknowledge.
// - Partner page bits 13:12 carry the partner remote fault code.
// - Partner page bits 8:7 carry the partner pause ability code.
// - Partner page bits 6 and 5 are half and full duplex; bits 4:0 read zero.
// - Management frames answer only at PHY address 0x01.
`ifndef PMR_PARAMS_SVH
`define PMR_PARAMS_SVH

`define PMR_PHY_ADDR      5'h01
`define PMR_ADDR_CTRL     5'h00
`define PMR_ADDR_LP_BASE  5'h05
`define PMR_ADDR_EXPAND   5'h06
`define PMR_ADDR_EXT_STAT 5'h0F

`define PMR_CTRL_RESET    16'h1140
`define PMR_CTRL_RW_MASK  16'h5180
`define PMR_CTRL_FIXED    16'h0040
`define PMR_EXPAND_RESET  16'h0004
`define PMR_EXT_RESET     16'hC000
`define PMR_LP_RESET      16'h0000
`define PMR_LP_MASK       16'hF1E0

`define PMR_BIT_RESET     4'hF
`define PMR_BIT_LOOPBACK  4'hE
`define PMR_BIT_AN_EN     4'hC
`define PMR_BIT_RESTART   4'h9
`define PMR_BIT_DUPLEX    4'h8
`define PMR_BIT_COL_TEST  4'h7
`define PMR_BIT_PAGE_RX   4'h1

`define PMR_PREAMBLE_LEN  6'h20
`define PMR_HDR_LAST      6'h0C
`define PMR_DATA_LAST     6'h0F
`define PMR_OP_READ       2'h2
`define PMR_OP_WRITE      2'h1

`endif

//--- hw/pmr_pkg.sv
// Types shared by the management register block.
package pmr_pkg;
    typedef enum logic [3:0] {
        PMR_ST_PRE  = 4'h1,
        PMR_ST_HDR  = 4'h2,
        PMR_ST_TA   = 4'h4,
        PMR_ST_DATA = 4'h8
    } pmr_frame_state_t;
endpackage : pmr_pkg

//--- hw/pmr_regbus_if.sv
// Internal register access path between the frame engine and the register bank.
`timescale 1ns/1ns
interface pmr_regbus_if;
    logic        rd_stb;
    logic        wr_stb;
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic [15:0] rdata;

    modport engine (output rd_stb, output wr_stb, output addr, output wdata, input rdata);
    modport bank   (input rd_stb, input wr_stb, input addr, input wdata, output rdata);
endinterface : pmr_regbus_if

//--- hw/pmr_sync3.sv
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ns
module pmr_sync3 #(
    parameter int W = 2
) (
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] level_out
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    s1_r[i]      <= 1'b0;
                    s2_r[i]      <= 1'b0;
                    s3_r[i]      <= 1'b0;
                    level_out[i] <= 1'b0;
                end else begin
                    s1_r[i] <= async_in[i];
                    s2_r[i] <= s1_r[i];
                    s3_r[i] <= s2_r[i];
                    if (s2_r[i] == s3_r[i]) begin
                        level_out[i] <= s3_r[i];
                    end
                end
            end
        end
    endgenerate
endmodule : pmr_sync3

//--- hw/pmr_reg_bank.sv
// Register bank: control, partner base page, expansion and extended status.
`timescale 1ns/1ns
`include "pmr_params.svh"
module pmr_reg_bank (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    pmr_regbus_if.bank       bus,
    input  wire logic [15:0] page_word_in,
    input  wire logic        page_rx_in,
    output logic             loopback_wrap_output_out,
    output logic             pcs_reset_out,
    output logic             an_enable_out,
    output logic             an_restart_out,
    output logic             full_duplex_out,
    output logic             col_test_out
);
    logic [15:0] ctrl_rw_r;
    logic [15:0] lp_page_r;
    logic        page_rcvd_r;
    logic        ctrl_wr;
    logic        soft_rst;
    logic [15:0] ctrl_view;
    logic [15:0] expand_view;

    assign ctrl_wr  = bus.wr_stb && (bus.addr == `PMR_ADDR_CTRL);
    assign soft_rst = ctrl_wr && bus.wdata[`PMR_BIT_RESET];

    // Only the writable bits are stored, so the fixed and self-clearing bits cannot drift.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_rw_r <= `PMR_CTRL_RESET & `PMR_CTRL_RW_MASK;
        end else if (soft_rst) begin
            ctrl_rw_r <= `PMR_CTRL_RESET & `PMR_CTRL_RW_MASK;
        end else if (ctrl_wr) begin
            ctrl_rw_r <= bus.wdata & `PMR_CTRL_RW_MASK;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pcs_reset_out  <= 1'b0;
            an_restart_out <= 1'b0;
        end else begin
            pcs_reset_out  <= soft_rst;
            an_restart_out <= ctrl_wr && bus.wdata[`PMR_BIT_RESTART];
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lp_page_r <= `PMR_LP_RESET;
        end else if (page_rx_in) begin
            lp_page_r <= page_word_in & `PMR_LP_MASK;
        end else if (soft_rst) begin
            lp_page_r <= `PMR_LP_RESET;
        end
    end

    // A page that lands in the cycle of the clearing read stays flagged.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            page_rcvd_r <= 1'b0;
        end else if (page_rx_in) begin
            page_rcvd_r <= 1'b1;
        end else if (soft_rst || (bus.rd_stb && bus.addr == `PMR_ADDR_EXPAND)) begin
            page_rcvd_r <= 1'b0;
        end
    end

    assign ctrl_view   = ctrl_rw_r | `PMR_CTRL_FIXED;
    assign expand_view = `PMR_EXPAND_RESET | {14'h0000, page_rcvd_r, 1'b0};

    always_comb begin
        unique case (bus.addr)
            `PMR_ADDR_CTRL:     bus.rdata = ctrl_view;
            `PMR_ADDR_LP_BASE:  bus.rdata = lp_page_r;
            `PMR_ADDR_EXPAND:   bus.rdata = expand_view;
            `PMR_ADDR_EXT_STAT: bus.rdata = `PMR_EXT_RESET;
            default:            bus.rdata = 16'h0000;
        endcase
    end

    assign loopback_wrap_output_out = ctrl_rw_r[`PMR_BIT_LOOPBACK];
    assign an_enable_out            = ctrl_rw_r[`PMR_BIT_AN_EN];
    assign full_duplex_out          = ctrl_rw_r[`PMR_BIT_DUPLEX];
    assign col_test_out             = ctrl_rw_r[`PMR_BIT_COL_TEST];

    property p_soft_reset_value;
        @(posedge clk_in) disable iff (!rst_n_in)
        soft_rst |=> (ctrl_view == `PMR_CTRL_RESET) && pcs_reset_out;
    endproperty
    a_soft_reset_value: assert property (p_soft_reset_value)
        else $error("Control did not return to its default after soft reset.");

    property p_wrap_follows;
        @(posedge clk_in) disable iff (!rst_n_in)
        (ctrl_wr && !soft_rst) |=> (loopback_wrap_output_out == $past(bus.wdata[14]));
    endproperty
    a_wrap_follows: assert property (p_wrap_follows)
        else $error("Wrap output does not follow control bit 14.");

    property p_fixed_bits;
        @(posedge clk_in) disable iff (!rst_n_in)
        !ctrl_view[13] && (ctrl_view[11:9] == 3'h0) && ctrl_view[6] && !ctrl_view[15];
    endproperty
    a_fixed_bits: assert property (p_fixed_bits)
        else $error("A fixed or self-clearing control bit read wrong.");

    property p_restart_pulse;
        @(posedge clk_in) disable iff (!rst_n_in)
        (ctrl_wr && bus.wdata[9]) |=> an_restart_out ##1 !an_restart_out;
    endproperty
    a_restart_pulse: assert property (p_restart_pulse)
        else $error("Restart pulse missing or too long.");

    property p_page_flag;
        @(posedge clk_in) disable iff (!rst_n_in)
        page_rx_in |=> expand_view[1] && (lp_page_r == ($past(page_word_in) & 16'hF1E0));
    endproperty
    a_page_flag: assert property (p_page_flag)
        else $error("Received page not flagged or not stored.");

    property p_static_regs;
        @(posedge clk_in) disable iff (!rst_n_in)
        (bus.addr == `PMR_ADDR_EXT_STAT) |-> (bus.rdata == 16'hC000);
    endproperty
    a_static_regs: assert property (p_static_regs)
        else $error("Extended status reads wrong.");
endmodule : pmr_reg_bank

//--- verif/pmr_host_model.sv
// Host-side model that drives management frames on the serial clock and data lines.
`timescale 1ns/1ns
module pmr_host_model #(
    parameter int HALF = 10
) (
    input  wire logic clk_in,
    input  wire logic dev_data_in,
    input  wire logic dev_oe_n_in,
    output logic      mdc_out,
    output logic      mdio_out
);
    logic host_en;
    logic host_bit;

    // The line has a pull-up, so a released line reads one and never a stale bit.
    assign mdio_out = !dev_oe_n_in ? dev_data_in : (host_en ? host_bit : 1'b1);

    initial begin
        mdc_out  = 1'b0;
        host_en  = 1'b0;
        host_bit = 1'b1;
    end

    // Data changes with the clock low and is sampled just before each rising edge.
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] regad,
                         input logic [15:0] wdata, output logic [15:0] rdata);
        logic [63:0] bits;
        logic        rd;
        bits  = {32'hFFFF_FFFF, 2'b01, op, phy, regad, 2'b10, wdata};
        rd    = (op == 2'h2);
        rdata = 16'h0000;
        for (int i = 63; i >= 0; i--) begin
            @(posedge clk_in);
            host_en  <= !(rd && i < 18);
            host_bit <= bits[i];
            mdc_out  <= 1'b0;
            repeat (HALF - 1) @(posedge clk_in);
            if (i < 16) rdata[i] = mdio_out;
            mdc_out <= 1'b1;
            repeat (HALF) @(posedge clk_in);
        end
        @(posedge clk_in);
        host_en <= 1'b0;
        mdc_out <= 1'b0;
        repeat (HALF) @(posedge clk_in);
    endtask : frame
endmodule : pmr_host_model

//--- verif/pcs_management_registers_tb.sv
// Self-checking bench for the management register block and its serial access.
`timescale 1ns/1ns
`include "pmr_params.svh"
module pcs_management_registers_tb;
    logic        clk_in;
    logic        rst_n_in;
    logic        tbi_mode;
    logic [15:0] page_word;
    logic        page_rx;
    logic        mdc;
    logic        mdio;
    logic        dev_data;
    logic        dev_oe_n;
    logic        wrap;
    logic        pcs_rst;
    logic        an_en;
    logic        an_rst;
    logic        fdx;
    logic        col;
    int          failures;
    int          n_tests;
    int          n_rst_pulse;
    int          n_restart_pulse;
    logic [15:0] rd_data;

    pmr_mgmt_top u_dut (
        .clk_in                   (clk_in),
        .rst_n_in                 (rst_n_in),
        .ten_bit_interface_mode_in(tbi_mode),
        .mgmt_clock_bit_in        (mdc),
        .mgmt_data_bit_in         (mdio),
        .mgmt_data_bit_out        (dev_data),
        .mgmt_data_oe_n_out       (dev_oe_n),
        .page_word_in             (page_word),
        .page_rx_in               (page_rx),
        .loopback_wrap_output_out (wrap),
        .pcs_reset_out            (pcs_rst),
        .an_enable_out            (an_en),
        .an_restart_out           (an_rst),
        .full_duplex_out          (fdx),
        .col_test_out             (col)
    );

    pmr_host_model u_host (
        .clk_in     (clk_in),
        .dev_data_in(dev_data),
        .dev_oe_n_in(dev_oe_n),
        .mdc_out    (mdc),
        .mdio_out   (mdio)
    );

    always #2 clk_in = ~clk_in;

    always @(posedge clk_in) begin
        if (pcs_rst === 1'b1) n_rst_pulse++;
        if (an_rst === 1'b1) n_restart_pulse++;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic rd(input logic [4:0] a, input logic [15:0] exp, input string what);
        u_host.frame(2'h2, `PMR_PHY_ADDR, a, 16'h0000, rd_data);
        check(rd_data, exp, what);
    endtask : rd

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        u_host.frame(2'h1, `PMR_PHY_ADDR, a, d, rd_data);
    endtask : wr

    // Order is wrap, negotiation enable, full duplex, collision test.
    task automatic outs(input logic [3:0] exp, input string what);
        check({12'h000, wrap, an_en, fdx, col}, {12'h000, exp}, what);
    endtask : outs

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    task automatic t_reset;
        rd(5'h00, 16'h1140, "control default");
        rd(5'h05, 16'h0000, "partner default");
        rd(5'h06, 16'h0004, "expansion default");
        rd(5'h0F, 16'hC000, "status default");
        outs(4'h6, "outputs after reset");
        $display("t_reset done");
    endtask : t_reset

    task automatic t_page;
        logic [15:0] w;
        for (int k = 0; k < 4; k++) begin
            w = 16'h0E1F | (16'(k) << 12) | (16'(k) << 7);
            w = w | (k[0] ? 16'hC000 : 16'h0000) | (k[1] ? 16'h0060 : 16'h0000);
            @(posedge clk_in);
            page_word <= w;
            page_rx   <= 1'b1;
            @(posedge clk_in);
            page_rx   <= 1'b0;
            rd(5'h05, w & 16'hF1E0, "partner page");
            rd(5'h06, 16'h0006, "page flag set");
        end
        rd(5'h06, 16'h0004, "page flag cleared");
        $display("t_page done");
    endtask : t_page

    task automatic t_ctrl;
        int p_rst;
        int p_rs;
        p_rst = n_rst_pulse;
        p_rs  = n_restart_pulse;
        wr(5'h00, 16'h7FFF);
        check(16'(n_restart_pulse - p_rs), 16'h0001, "restart pulse");
        check(16'(n_rst_pulse - p_rst), 16'h0000, "no reset pulse");
        outs(4'hF, "controls set");
        rd(5'h00, 16'h51C0, "control fixed bits");
        wr(5'h00, 16'h0000);
        outs(4'h0, "controls clear");
        rd(5'h00, 16'h0040, "speed bits fixed");
        wr(5'h00, 16'h8000);
        check(16'(n_rst_pulse - p_rst), 16'h0001, "reset pulse");
        rd(5'h00, 16'h1140, "control after soft reset");
        rd(5'h05, 16'h0000, "partner after soft reset");
        outs(4'h6, "outputs after soft reset");
        $display("t_ctrl done");
    endtask : t_ctrl

    task automatic t_refuse;
        u_host.frame(2'h1, 5'h02, 5'h00, 16'h4000, rd_data);
        outs(4'h6, "foreign address write");
        u_host.frame(2'h2, 5'h02, 5'h0F, 16'h0000, rd_data);
        check(rd_data, 16'hFFFF, "foreign address read");
        @(posedge clk_in);
        tbi_mode <= 1'b0;
        wr(5'h00, 16'h4000);
        tbi_mode <= 1'b1;
        outs(4'h6, "write outside ten-bit mode");
        rd(5'h03, 16'h0000, "unmapped read");
        wr(5'h0F, 16'h0000);
        rd(5'h0F, 16'hC000, "status is read-only");
        $display("t_refuse done");
    endtask : t_refuse

    initial begin
        repeat (90000) @(posedge clk_in);
        failures++;
        $display("[FAIL] t=%0t run did not finish in time", $time);
        complete_run();
    end

    initial begin
        clk_in          = 1'b0;
        rst_n_in        = 1'b0;
        tbi_mode        = 1'b1;
        page_word       = 16'h0000;
        page_rx         = 1'b0;
        failures        = 0;
        n_tests         = 0;
        n_rst_pulse     = 0;
        n_restart_pulse = 0;
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (8) @(posedge clk_in);
        t_reset();
        t_page();
        t_ctrl();
        t_refuse();
        complete_run();
    end
endmodule : pcs_management_registers_tb
